//--- dv/amdsl_regs_asserts.sv
// Checker: port-level properties of the AM drive level register bank
`timescale 1ns/100ps
module amdsl_regs_asserts
    import amdsl_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire amdsl_bus_req_t bus_req,
    input wire logic [DATA_W-1:0] bus_rdata,
    input wire logic restore_defaults,
    input wire amdsl_cal_t cal_in,
    input wire logic am_modulate,
    input wire logic [DEPTH_W-1:0] depth_target,
    input wire logic [SEG_N-1:0] segment_enable,
    input wire logic antenna_driver_tristate,
    input wire logic irq
);
    logic [DATA_W-1:0] wd1_q;
    logic [DATA_W-1:0] wd2_q;
    // Write data history for delayed compares
    always_ff @(posedge clock) begin
        wd1_q <= bus_req.wdata;
        wd2_q <= wd1_q;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_quiet;
        !bus_req.wr && !restore_defaults && !cal_in.done && !am_modulate;
    endsequence
    sequence s_wr(logic [7:0] a);
        bus_req.wr && bus_req.addr == a && !restore_defaults && !cal_in.done && !am_modulate;
    endsequence
    sequence s_cal_rd(logic f);
        cal_in.done && cal_in.fail == f && !restore_defaults ##1
            bus_req.rd && bus_req.addr == 8'h25 && !restore_defaults && !cal_in.done;
    endsequence
    a_normal_mask: assert property (s_wr(8'h27) ##1 s_quiet |=> segment_enable == ~wd2_q)
        else $error("normal mask not applied");
    a_tristate_on: assert property (s_wr(8'h27) ##1 s_quiet
        |=> antenna_driver_tristate == (wd2_q == 8'hFF))
        else $error("tristate does not follow normal mask");
    a_tristate_seg: assert property (antenna_driver_tristate |-> segment_enable == 8'h00)
        else $error("segments on while tristate");
    a_mod_no_tri: assert property (am_modulate |=> !antenna_driver_tristate)
        else $error("tristate while modulated");
    a_cal_fail: assert property (s_cal_rd(1'b1) |=> bus_rdata == 8'hFF)
        else $error("failed calibration result wrong");
    a_cal_pass: assert property (s_cal_rd(1'b0) |=> bus_rdata == $past(cal_in.mask, 2))
        else $error("calibration result wrong");
    a_ctrl_bit0: assert property (bus_req.rd && bus_req.addr == 8'h24 |=> !bus_rdata[0])
        else $error("control bit 0 not zero");
    a_depth_field: assert property (s_wr(8'h24) ##1 s_quiet |=> depth_target == wd2_q[6:1])
        else $error("depth target wrong");
    a_restore_clear: assert property (restore_defaults && !bus_req.wr && !cal_in.done ##1 s_quiet
        |=> segment_enable == 8'hFF && depth_target == 6'h00)
        else $error("defaults not restored");
endmodule

bind amdsl_regs amdsl_regs_asserts u_amdsl_regs_asserts (.clock(clock), .rst(rst),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .restore_defaults(restore_defaults),
    .cal_in(cal_in), .am_modulate(am_modulate), .depth_target(depth_target),
    .segment_enable(segment_enable), .antenna_driver_tristate(antenna_driver_tristate),
    .irq(irq));

//--- dv/amdsl_regs_tb.sv
// Testbench: register bank, drive level selection and interrupt scenarios
`timescale 1ns/100ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
    $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module amdsl_regs_tb;
    import amdsl_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    amdsl_bus_req_t bus_req = '0;
    logic [DATA_W-1:0] bus_rdata;
    logic restore_defaults = 1'b0;
    amdsl_cal_t cal_in = '0;
    logic am_modulate = 1'b0;
    logic [DEPTH_W-1:0] depth_target;
    logic [SEG_N-1:0] segment_enable;
    logic antenna_driver_tristate;
    logic irq;
    logic [8:0] drive_strength;
    int miscompares = 0;
    int samples_checked = 0;
    // ------------------------------------------------------------------
    // Instances and clock
    // ------------------------------------------------------------------
    amdsl_regs u_amdsl_regs (.clock(clock), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .restore_defaults(restore_defaults), .cal_in(cal_in), .am_modulate(am_modulate),
        .depth_target(depth_target), .segment_enable(segment_enable),
        .antenna_driver_tristate(antenna_driver_tristate), .irq(irq));
    amdsl_tank u_amdsl_tank (.segment_enable(segment_enable),
        .antenna_driver_tristate(antenna_driver_tristate), .drive_strength(drive_strength));
    // Free-running 125 MHz clock
    always #4 clock = ~clock;
    // ------------------------------------------------------------------
    // Bus and stimulus tasks
    // ------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus_req <= '0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus_req <= '0;
        #1;
        `CHK(bus_rdata, e)
    endtask
    task automatic cal(input logic f, input logic [7:0] m);
        @(posedge clock);
        cal_in <= '{done: 1'b1, fail: f, mask: m};
        @(posedge clock);
        cal_in <= '0;
    endtask
    task automatic cal_rd(input logic f, input logic [7:0] m, input logic [7:0] e);
        @(posedge clock);
        cal_in <= '{done: 1'b1, fail: f, mask: m};
        @(posedge clock);
        cal_in <= '0;
        bus_req <= '{addr: 8'h25, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus_req <= '0;
        #1;
        `CHK(bus_rdata, e)
    endtask
    task automatic settle;
        repeat (3) @(posedge clock);
        #1;
    endtask
    task automatic set_mod(input logic m);
        @(posedge clock);
        am_modulate <= m;
        settle();
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        rd_chk(8'h24, 8'h00);
        rd_chk(8'h25, 8'h00);
        rd_chk(8'h26, 8'h00);
        rd_chk(8'h27, 8'h00);
        `CHK(drive_strength, 9'h0FF)
    endtask
    task automatic t_normal;
        wr(8'h27, 8'hC0);
        settle();
        `CHK(segment_enable, 8'h3F)
        `CHK(drive_strength, 9'h03F)
        wr(8'h27, 8'hFF);
        settle();
        `CHK(antenna_driver_tristate, 1'b1)
        rd_chk(8'h32, 8'h01);
        set_mod(1'b1);
        `CHK(antenna_driver_tristate, 1'b0)
        set_mod(1'b0);
        wr(8'h27, 8'h00);
    endtask
    task automatic t_am_level;
        cal(1'b0, 8'h0F);
        wr(8'h26, 8'hA5);
        wr(8'h24, 8'h80);
        set_mod(1'b1);
        `CHK(segment_enable, 8'h5A)
        rd_chk(8'h32, 8'h06);
        wr(8'h24, 8'h00);
        settle();
        `CHK(segment_enable, 8'hF0)
        set_mod(1'b0);
        `CHK(segment_enable, 8'hFF)
    endtask
    task automatic t_cal;
        wr(8'h24, 8'h7F);
        rd_chk(8'h24, 8'h7E);
        `CHK(depth_target, 6'h3F)
        cal_rd(1'b0, 8'h3C, 8'h3C);
        wr(8'h25, 8'h00);
        rd_chk(8'h25, 8'h3C);
        cal_rd(1'b1, 8'h12, 8'hFF);
        rd_chk(8'h40, 8'h00);
    endtask
    task automatic t_irq;
        rd_chk(8'h30, 8'h07);
        wr(8'h31, 8'h03);
        settle();
        `CHK(irq, 1'b1)
        wr(8'h30, 8'h07);
        settle();
        `CHK(irq, 1'b0)
        wr(8'h31, 8'h00);
        cal(1'b0, 8'h01);
        settle();
        `CHK(irq, 1'b0)
        wr(8'h31, 8'h01);
        settle();
        `CHK(irq, 1'b1)
        wr(8'h30, 8'h01);
    endtask
    task automatic t_defaults;
        wr(8'h26, 8'h33);
        wr(8'h27, 8'h44);
        @(posedge clock);
        restore_defaults <= 1'b1;
        @(posedge clock);
        restore_defaults <= 1'b0;
        settle();
        rd_chk(8'h24, 8'h00);
        rd_chk(8'h25, 8'h00);
        rd_chk(8'h26, 8'h00);
        rd_chk(8'h27, 8'h00);
    endtask
    // ------------------------------------------------------------------
    // Verdict, watchdog and main sequence
    // ------------------------------------------------------------------
    task automatic wrap_up;
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Cuts a hang short well past the expected run length
    initial begin
        #20000;
        miscompares++;
        wrap_up();
    end
    // Reset then the scenarios in order
    initial begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_normal();
        t_am_level();
        t_cal();
        t_irq();
        t_defaults();
        wrap_up();
    end
endmodule

//--- dv/amdsl_tank.sv
// Antenna tank model: drive strength seen from the enabled driver segments
`timescale 1ns/100ps
module amdsl_tank (
    input wire logic [amdsl_pkg::SEG_N-1:0] segment_enable,
    input wire logic antenna_driver_tristate,
    output logic [8:0] drive_strength
);
    import amdsl_pkg::*;
    always_comb begin
        drive_strength = antenna_driver_tristate ? 9'h000 : {1'b0, segment_enable};
    end
endmodule

//--- include/amdsl_pkg.sv
// Package: register map, field layout and carriers for the AM drive level register bank
// Function
// RL1: Select 0: depth target steers modulated level
// RL2: Select 1: modulated level from AM mask
// RL3: Read-only result: ones disable modulated segments
// RL4: Failed calibration loads all ones result
// RL5: AM mask disables segments only when select=1
// RL6: Normal mask disables segments when unmodulated
// RL7: Bit 7 is 2 Ohm, bit 0 256 Ohm
// RL8: Normal mask all ones tristates the drivers
// RL9: Control and masks clear on reset, defaults
// RL10: Result register clears on reset, defaults
// RL11: Select 0: result register is modulated mask
// RL12: Writes to result, control bit 0 ignored
package amdsl_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int SEG_N = 8;
    localparam int DEPTH_W = 6;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] AM_DEPTH_CONTROL_OFS = 8'h24;
    localparam logic [ADDR_W-1:0] AM_DEPTH_RESULT_OFS = 8'h25;
    localparam logic [ADDR_W-1:0] AM_LEVEL_SEGMENT_MASK_OFS = 8'h26;
    localparam logic [ADDR_W-1:0] NORMAL_LEVEL_SEGMENT_MASK_OFS = 8'h27;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 8'h30;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h31;
    localparam logic [ADDR_W-1:0] DRIVE_STATE_OFS = 8'h32;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int LEVEL_SOURCE_SELECT_POS = 7;
    localparam int DEPTH_TARGET_MSB_POS = 6;
    localparam int DEPTH_TARGET_LSB_POS = 1;
    localparam int IRQ_CAL_DONE_POS = 0;
    localparam int IRQ_CAL_FAIL_POS = 1;
    localparam int IRQ_TRISTATE_POS = 2;
    localparam int IRQ_N = 3;
    localparam int STATE_TRISTATE_POS = 0;
    localparam int STATE_MODULATED_POS = 1;
    localparam int STATE_SOURCE_POS = 2;

    // ------------------------------------------------------------------
    // Reset and special values
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] REG_RESET_VAL = 8'h00;
    localparam logic [DATA_W-1:0] CAL_FAIL_VAL = 8'hFF;
    localparam logic [SEG_N-1:0] ALL_SEG_OFF = 8'hFF;
    localparam logic [IRQ_N-1:0] IRQ_RESET_VAL = 3'h0;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } amdsl_bus_req_t;

    typedef struct packed {
        logic done;
        logic fail;
        logic [SEG_N-1:0] mask;
    } amdsl_cal_t;

endpackage

//--- verilog/amdsl_regs.sv
// Module: AM drive level register bank with segment mask selection and interrupt
`timescale 1ns/100ps
module amdsl_regs (
    input wire logic clock,
    input wire logic rst,
    input wire amdsl_pkg::amdsl_bus_req_t bus_req,
    output logic [amdsl_pkg::DATA_W-1:0] bus_rdata,
    input wire logic restore_defaults,
    input wire amdsl_pkg::amdsl_cal_t cal_in,
    input wire logic am_modulate,
    output logic [amdsl_pkg::DEPTH_W-1:0] depth_target,
    output logic [amdsl_pkg::SEG_N-1:0] segment_enable,
    output logic antenna_driver_tristate,
    output logic irq
);
    import amdsl_pkg::*;

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic level_source_select_q;
    logic [DEPTH_W-1:0] depth_target_q;
    logic [DATA_W-1:0] am_depth_result_q;
    logic [SEG_N-1:0] am_level_segment_mask_q;
    logic [SEG_N-1:0] normal_level_segment_mask_q;
    logic [IRQ_N-1:0] irq_status_q;
    logic [IRQ_N-1:0] irq_status_d;
    logic [IRQ_N-1:0] irq_mask_q;
    logic [IRQ_N-1:0] irq_mask_d;
    logic [DATA_W-1:0] bus_rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic [SEG_N-1:0] segment_enable_q;
    logic antenna_driver_tristate_q;
    logic irq_q;
    logic drive_modulated_q;

    // ------------------------------------------------------------------
    // Decoded strobes
    // ------------------------------------------------------------------
    logic wr_control;
    logic wr_am_mask;
    logic wr_normal_mask;
    logic wr_irq_status;
    logic wr_irq_mask;
    logic defaults;

    // Address decode of write strobes
    assign wr_control = bus_req.wr && (bus_req.addr == AM_DEPTH_CONTROL_OFS);
    assign wr_am_mask = bus_req.wr && (bus_req.addr == AM_LEVEL_SEGMENT_MASK_OFS);
    assign wr_normal_mask = bus_req.wr && (bus_req.addr == NORMAL_LEVEL_SEGMENT_MASK_OFS);
    assign wr_irq_status = bus_req.wr && (bus_req.addr == IRQ_STATUS_OFS);
    assign wr_irq_mask = bus_req.wr && (bus_req.addr == IRQ_MASK_OFS);

    // Power-up and restore-defaults share one clearing path
    assign defaults = rst || restore_defaults;

    // ------------------------------------------------------------------
    // Depth control register
    // ------------------------------------------------------------------

    // Select bit and depth target; bit 0 is not stored
    always_ff @(posedge clock) begin
        // RL9 clear on defaults
        if (defaults) begin
            level_source_select_q <= REG_RESET_VAL[LEVEL_SOURCE_SELECT_POS];
            depth_target_q <= REG_RESET_VAL[DEPTH_TARGET_MSB_POS:DEPTH_TARGET_LSB_POS];
        end else if (wr_control) begin
            level_source_select_q <= bus_req.wdata[LEVEL_SOURCE_SELECT_POS];
            // RL12 bit 0 dropped
            depth_target_q <= bus_req.wdata[DEPTH_TARGET_MSB_POS:DEPTH_TARGET_LSB_POS];
        end
    end

    // ------------------------------------------------------------------
    // Calibration result register
    // ------------------------------------------------------------------

    // Loaded only by the calibration engine, never by the bus
    always_ff @(posedge clock) begin
        // RL10 clear on defaults
        if (defaults) begin
            am_depth_result_q <= REG_RESET_VAL;
        // A failed run ignores the mask that came with it
        // RL4 failure forces ones
        end else if (cal_in.done && cal_in.fail) begin
            am_depth_result_q <= CAL_FAIL_VAL;
        // RL3 store calibrated segments
        end else if (cal_in.done) begin
            am_depth_result_q <= cal_in.mask;
        end
    end

    // ------------------------------------------------------------------
    // Segment mask registers
    // ------------------------------------------------------------------

    // AM modulated level mask
    always_ff @(posedge clock) begin
        // RL9 clear on defaults
        if (defaults) begin
            am_level_segment_mask_q <= REG_RESET_VAL;
        end else if (wr_am_mask) begin
            am_level_segment_mask_q <= bus_req.wdata;
        end
    end

    // Normal unmodulated level mask
    always_ff @(posedge clock) begin
        // RL9 clear on defaults
        if (defaults) begin
            normal_level_segment_mask_q <= REG_RESET_VAL;
        end else if (wr_normal_mask) begin
            normal_level_segment_mask_q <= bus_req.wdata;
        end
    end

    // ------------------------------------------------------------------
    // Driver segment control
    // ------------------------------------------------------------------
    logic [SEG_N-1:0] am_disable;
    logic [SEG_N-1:0] active_disable;

    // Modulated disable mask chosen by the level source select bit
    always_comb begin
        if (level_source_select_q) begin
            // RL2 direct mask source
            am_disable = am_level_segment_mask_q;
        end else begin
            // RL1 RL11 calibrated source
            am_disable = am_depth_result_q;
        end
    end

    // RL5 RL6 state picks mask
    assign active_disable = am_modulate ? am_disable : normal_level_segment_mask_q;

    // One flop per segment; index i drives the weight 2^(8-i) Ohm
    genvar seg;
    generate
        for (seg = 0; seg < SEG_N; seg++) begin : g_seg
            // RL7 bit 7 strongest segment
            always_ff @(posedge clock) begin
                // Reset holds every segment off; defaults only clear the control, result and mask registers
                if (rst) begin
                    segment_enable_q[seg] <= 1'b0;
                end else begin
                    segment_enable_q[seg] <= ~active_disable[seg];
                end
            end
        end
    endgenerate

    // Tristate flag while every normal segment is off
    // Only unmodulated; a modulated burst keeps its AM mask
    always_ff @(posedge clock) begin
        if (rst) begin
            antenna_driver_tristate_q <= 1'b0;
        end else begin
            // RL8 all ones tristates
            antenna_driver_tristate_q <= !am_modulate
                && (normal_level_segment_mask_q == ALL_SEG_OFF);
        end
    end

    // Modulation state copy for the state register
    always_ff @(posedge clock) begin
        if (rst) begin
            drive_modulated_q <= 1'b0;
        end else begin
            drive_modulated_q <= am_modulate;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------
    logic [IRQ_N-1:0] irq_event;
    logic tristate_prev_q;

    // Events: calibration done, calibration failed, drivers entered tristate
    assign irq_event[IRQ_CAL_DONE_POS] = cal_in.done;
    assign irq_event[IRQ_CAL_FAIL_POS] = cal_in.done && cal_in.fail;
    assign irq_event[IRQ_TRISTATE_POS] = antenna_driver_tristate_q && !tristate_prev_q;

    // Tristate edge history
    always_ff @(posedge clock) begin
        if (rst) begin
            tristate_prev_q <= 1'b0;
        end else begin
            tristate_prev_q <= antenna_driver_tristate_q;
        end
    end

    // Write one to clear; a new event in the same cycle wins
    always_comb begin
        irq_status_d = irq_status_q;
        if (wr_irq_status) begin
            irq_status_d = irq_status_q & ~bus_req.wdata[IRQ_N-1:0];
        end
        // Events merge after the clear, so a same-cycle event survives
        irq_status_d = irq_status_d | irq_event;
    end

    // Sticky status bits
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_status_q <= IRQ_RESET_VAL;
        end else begin
            irq_status_q <= irq_status_d;
        end
    end

    // Mask next value, so the line never lags a mask write
    always_comb begin
        irq_mask_d = irq_mask_q;
        if (wr_irq_mask) begin
            irq_mask_d = bus_req.wdata[IRQ_N-1:0];
        end
    end

    // Interrupt mask, one enables the matching status bit
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_mask_q <= IRQ_RESET_VAL;
        end else begin
            irq_mask_q <= irq_mask_d;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt line
    // ------------------------------------------------------------------

    // Level interrupt from the next status and mask values
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_status_d & irq_mask_d);
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------

    // Read mux; unmapped addresses return zero
    always_comb begin
        rdata_d = '0;
        case (bus_req.addr)
            // Unused bit 0 stays zero on readback
            AM_DEPTH_CONTROL_OFS: begin
                rdata_d[LEVEL_SOURCE_SELECT_POS] = level_source_select_q;
                rdata_d[DEPTH_TARGET_MSB_POS:DEPTH_TARGET_LSB_POS] = depth_target_q;
            end
            AM_DEPTH_RESULT_OFS: begin
                // RL3 result readback
                rdata_d = am_depth_result_q;
            end
            AM_LEVEL_SEGMENT_MASK_OFS: begin
                rdata_d = am_level_segment_mask_q;
            end
            NORMAL_LEVEL_SEGMENT_MASK_OFS: begin
                rdata_d = normal_level_segment_mask_q;
            end
            IRQ_STATUS_OFS: begin
                rdata_d[IRQ_N-1:0] = irq_status_q;
            end
            IRQ_MASK_OFS: begin
                rdata_d[IRQ_N-1:0] = irq_mask_q;
            end
            DRIVE_STATE_OFS: begin
                rdata_d[STATE_TRISTATE_POS] = antenna_driver_tristate_q;
                rdata_d[STATE_MODULATED_POS] = drive_modulated_q;
                rdata_d[STATE_SOURCE_POS] = level_source_select_q;
            end
            default: begin
                rdata_d = '0;
            end
        endcase
    end

    // Read data stands for one cycle after the read strobe
    always_ff @(posedge clock) begin
        if (rst) begin
            bus_rdata_q <= '0;
        end else if (bus_req.rd) begin
            bus_rdata_q <= rdata_d;
        end else begin
            // Idle cycles read zero, so stale data never looks valid
            bus_rdata_q <= '0;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign bus_rdata = bus_rdata_q;
    assign depth_target = depth_target_q;
    assign segment_enable = segment_enable_q;
    assign antenna_driver_tristate = antenna_driver_tristate_q;
    assign irq = irq_q;

endmodule
